// *** rtl/adcc_control.sv ***
/*
 * Control and status logic of a four-channel 8-bit converter with two
 * analog output enables: control register, result register, start and
 * completion handshake, and a maskable interrupt.
 * Assumes the analog core presents its result on convData by the time
 * the sequencer signals completion, and that rcTick is synchronous.
 */
// The register offsets and the plain strobed port were decided locally.

// What this block does
// R1 - Bit 6 enables second output converter
// R2 - Bit 5 enables first output converter
// R3 - Bit 5 writable only when idle
// R4 - Software avoids converter and output0 both on
// R5 - Completion sets done flag, raises interrupt
// R6 - Done flag cleared only by software
// R7 - Writing start runs conversion, self-clears
// R8 - Both status bits zero: start accepted
// R9 - Busy: further starts blocked
// R10 - Done set: starts refused until cleared
// R11 - Start at completion reads both one
// R12 - Bit 2 selects CPU or RC clocking
// R13 - Channel field picks input, frozen while busy
// R14 - Software waits ten microseconds after enable
// R15 - CPU clocked conversion takes 31 machine cycles
// R16 - Result loaded at completion, held until next completion
module adcc_control
	import adcc_pkg::*;
(
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	input  wire logic [adcc_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [adcc_pkg::DATA_W-1:0]  regWdata,
	input  wire logic                         regWr,
	input  wire logic                         regRd,
	output logic      [adcc_pkg::DATA_W-1:0]  regRdata,
	input  wire logic                         rcTick,
	input  wire logic [adcc_pkg::DATA_W-1:0]  convData,
	output logic                              converterEnable,
	output logic                              analogOut0Enable,
	output logic                              analogOut1Enable,
	output logic                              rcClockSelect,
	output logic      [1:0]                   channelSelect,
	output logic                              convStart,
	output logic                              irq
);

	import adcc_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic                convEn_ff;
	logic                nxt_convEn;
	logic                out1En_ff;
	logic                nxt_out1En;
	logic                out0En_ff;
	logic                nxt_out0En;
	logic                doneFlag_ff;
	logic                nxt_doneFlag;
	logic                startBusy_ff;
	logic                nxt_startBusy;
	logic                rcSel_ff;
	logic                nxt_rcSel;
	logic [1:0]          chanSel_ff;
	logic [1:0]          nxt_chanSel;
	logic [DATA_W-1:0]   result_ff;
	logic [DATA_W-1:0]   nxt_result;
	logic [IRQ_W-1:0]    irqSts_ff;
	logic [IRQ_W-1:0]    nxt_irqSts;
	logic [IRQ_W-1:0]    irqMsk_ff;
	logic [IRQ_W-1:0]    nxt_irqMsk;
	logic [DATA_W-1:0]   rdata_ff;
	logic [DATA_W-1:0]   nxt_rdata;
	logic                startPulse_ff;
	logic                nxt_startPulse;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// One register hit per strobe; shared by every select below
	function automatic logic regHit(
		input logic              strobe,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target
	);
		return strobe && (addr == target);
	endfunction : regHit

	// Narrow interrupt words read back with zeros above them
	function automatic logic [DATA_W-1:0] irqWord(input logic [IRQ_W-1:0] bits);
		return {{(DATA_W-IRQ_W){1'b0}}, bits};
	endfunction : irqWord

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic           wrCtrl;
	wire logic           wrIrqSts;
	wire logic           wrIrqMsk;
	wire logic           idleNow;
	wire logic           startReq;
	wire logic           startOk;
	wire logic           startRefused;
	wire logic           doneClearWr;
	wire logic           convDone;
	wire logic           seqRunning;
	wire logic [DATA_W-1:0] ctrlView;
	wire logic [IRQ_W-1:0]  irqEvents;

	// Register select strobes
	assign wrCtrl   = regHit(regWr, regAddr, ADDR_CTRL);
	assign wrIrqSts = regHit(regWr, regAddr, ADDR_IRQSTS);
	assign wrIrqMsk = regHit(regWr, regAddr, ADDR_IRQMSK);

	// Idle means neither status bit is set
	assign idleNow      = !doneFlag_ff && !startBusy_ff;                      // [R8]
	assign startReq     = wrCtrl && regWdata[BIT_START];
	assign startOk      = startReq && idleNow;                                // [R8]
	// Busy or finished-but-unacknowledged both turn a start away
	assign startRefused = startReq && !idleNow;                               // [R9] [R10]
	assign doneClearWr  = wrCtrl && !regWdata[BIT_DONE];                      // [R6]

	// Control register as software sees it
	assign ctrlView = {convEn_ff, out1En_ff, out0En_ff, doneFlag_ff,
	                   startBusy_ff, rcSel_ff, chanSel_ff};

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// Clock source and count live in the sequencer; this block launches
	adcc_conv_timer uTimer (
		.mclk       (mclk),
		.nrst       (nrst),
		.startPulse (startPulse_ff),
		.useRc      (rcSel_ff),
		.rcTick     (rcTick),
		.running    (seqRunning),
		.donePulse  (convDone)
	);

	// ----------------------------------------------------------------
	// Control register next values
	// ----------------------------------------------------------------
	// Enable bits and clock select with no interlock
	always_comb begin
		nxt_convEn = convEn_ff;
		nxt_out1En = out1En_ff;
		nxt_rcSel  = rcSel_ff;
		if (wrCtrl) begin
			nxt_convEn = regWdata[BIT_CONV_EN];
			nxt_out1En = regWdata[BIT_OUT1_EN];                                 // [R1]
			nxt_rcSel  = regWdata[BIT_RC_SEL];                                  // [R12]
		end
	end

	// Output 0 shares the converter's ladder, so it only moves while idle
	always_comb begin
		nxt_out0En = out0En_ff;
		if (wrCtrl && idleNow) begin
			nxt_out0En = regWdata[BIT_OUT0_EN];                                 // [R3] [R2]
		end
	end

	// Channel is frozen once a conversion or an unread result exists;
	// a start write may carry a new channel in the same access
	always_comb begin
		nxt_chanSel = chanSel_ff;
		if (wrCtrl && idleNow) begin
			nxt_chanSel = regWdata[BIT_CHAN_HI:BIT_CHAN_LO];                    // [R13]
		end
	end

	// Done flag: hardware only sets it; a completion beats a clear
	always_comb begin
		nxt_doneFlag = doneFlag_ff;
		if (convDone) begin
			nxt_doneFlag = 1'b1;                                                // [R5]
		end else if (doneClearWr) begin
			nxt_doneFlag = 1'b0;                                                // [R6]
		end
	end

	// Start/busy bit
	// A start that meets a completion is not queued: the sequencer is
	// already retiring, and running it would overwrite a result that
	// software has not seen yet. Software clears done and starts again.
	always_comb begin
		nxt_startBusy = startBusy_ff;
		if (convDone) begin
			// A start landing on completion is kept visible but not run
			nxt_startBusy = startReq;                                           // [R7] [R11]
		end else if (startOk) begin
			nxt_startBusy = 1'b1;                                               // [R7]
		end else if (doneClearWr && doneFlag_ff && !seqRunning) begin
			// Clearing done retires a leftover start from a coincidence
			nxt_startBusy = 1'b0;                                               // [R11]
		end
	end

	// Launch pulse to the sequencer and analog core
	assign nxt_startPulse = startOk;                                          // [R7]

	// ----------------------------------------------------------------
	// Result register
	// ----------------------------------------------------------------
	// Held from completion until the next conversion delivers
	always_comb begin
		nxt_result = result_ff;
		if (convDone) begin
			nxt_result = convData;                                              // [R16]
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	assign irqEvents[IRQ_BIT_DONE]   = convDone;                              // [R5]
	assign irqEvents[IRQ_BIT_REFUSE] = startRefused;

	// Write-one-to-clear; a new event in the same cycle wins
	always_comb begin
		nxt_irqSts = irqSts_ff;
		if (wrIrqSts) begin
			nxt_irqSts = irqSts_ff & ~regWdata[IRQ_W-1:0];
		end
		nxt_irqSts = nxt_irqSts | irqEvents;
	end

	// Mask register
	always_comb begin
		nxt_irqMsk = irqMsk_ff;
		if (wrIrqMsk) begin
			nxt_irqMsk = regWdata[IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Data stand one cycle after the strobe and read zero otherwise
	// Unmapped offsets read zero so software can probe the map safely
	always_comb begin
		nxt_rdata = '0;
		if (regRd) begin
			case (regAddr)
				ADDR_CTRL:   nxt_rdata = ctrlView;
				ADDR_RESULT: nxt_rdata = result_ff;
				ADDR_IRQSTS: nxt_rdata = irqWord(irqSts_ff);
				ADDR_IRQMSK: nxt_rdata = irqWord(irqMsk_ff);
				default:     nxt_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flip-flops
	// ----------------------------------------------------------------
	// Enables and clock select; reset leaves every analog path off
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			convEn_ff <= CTRL_RESET[BIT_CONV_EN];
			out1En_ff <= CTRL_RESET[BIT_OUT1_EN];
			out0En_ff <= CTRL_RESET[BIT_OUT0_EN];
			rcSel_ff  <= CTRL_RESET[BIT_RC_SEL];
		end else begin
			convEn_ff <= nxt_convEn;
			out1En_ff <= nxt_out1En;
			out0En_ff <= nxt_out0En;
			rcSel_ff  <= nxt_rcSel;
		end
	end

	// Status pair; kept together since both feed the idle decode
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			doneFlag_ff  <= CTRL_RESET[BIT_DONE];
			startBusy_ff <= CTRL_RESET[BIT_START];
		end else begin
			doneFlag_ff  <= nxt_doneFlag;
			startBusy_ff <= nxt_startBusy;
		end
	end

	// Channel field
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			chanSel_ff <= CTRL_RESET[BIT_CHAN_HI:BIT_CHAN_LO];
		end else begin
			chanSel_ff <= nxt_chanSel;
		end
	end

	// Result, held between completions
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			result_ff <= RESULT_RESET;
		end else begin
			result_ff <= nxt_result;
		end
	end

	// Interrupt status and mask
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqSts_ff <= IRQ_RESET;
			irqMsk_ff <= IRQ_RESET;
		end else begin
			irqSts_ff <= nxt_irqSts;
			irqMsk_ff <= nxt_irqMsk;
		end
	end

	// Read data and launch pulse, both one-cycle registered outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff      <= '0;
			startPulse_ff <= 1'b0;
		end else begin
			rdata_ff      <= nxt_rdata;
			startPulse_ff <= nxt_startPulse;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Enables drive the analog core straight from their flops;
	// nothing here stops software enabling converter and output 0 together
	assign converterEnable  = convEn_ff;
	assign analogOut1Enable = out1En_ff;                                      // [R1]
	assign analogOut0Enable = out0En_ff;                                      // [R2]
	assign rcClockSelect    = rcSel_ff;                                       // [R12]
	assign channelSelect    = chanSel_ff;                                     // [R13]
	assign convStart        = startPulse_ff;
	assign regRdata         = rdata_ff;

	// Level interrupt while any unmasked event is pending
	assign irq = |(irqSts_ff & irqMsk_ff);                                    // [R5]

endmodule : adcc_control

// *** rtl/adcc_pkg.sv ***
/*
 * Constants shared by the converter control block: register offsets,
 * control field positions, reset values and conversion timing counts.
 * Assumes a single 200 MHz clock and byte-wide software registers.
 */
package adcc_pkg;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_IRQSTS = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_IRQMSK = 4'h3;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned BIT_CONV_EN   = 7;
	localparam int unsigned BIT_OUT1_EN   = 6;
	localparam int unsigned BIT_OUT0_EN   = 5;
	localparam int unsigned BIT_DONE      = 4;
	localparam int unsigned BIT_START     = 3;
	localparam int unsigned BIT_RC_SEL    = 2;
	localparam int unsigned BIT_CHAN_HI   = 1;
	localparam int unsigned BIT_CHAN_LO   = 0;

	localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Interrupt status and mask fields
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_W          = 2;
	localparam int unsigned IRQ_BIT_DONE   = 0;
	localparam int unsigned IRQ_BIT_REFUSE = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Conversion timing
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W          = 8;
	localparam int unsigned CLKS_PER_MC    = 6;   // Oscillator clocks per machine cycle
	localparam int unsigned CONV_MC        = 31;  // Conversion length on the CPU clock
	localparam int unsigned RC_SYNC_MC     = 3;   // Hand-over before RC clocking
	localparam int unsigned RC_CONV_TICKS  = 108; // RC clocks per conversion
	localparam logic [CNT_W-1:0] CPU_CONV_CLKS = CNT_W'(CONV_MC * CLKS_PER_MC);
	localparam logic [CNT_W-1:0] RC_SYNC_CLKS  = CNT_W'(RC_SYNC_MC * CLKS_PER_MC);
	localparam logic [CNT_W-1:0] RC_TICKS      = CNT_W'(RC_CONV_TICKS);
	localparam logic [CNT_W-1:0] CNT_ONE       = 8'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO      = 8'h00;

	// Conversion sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_SYNC = 2'b01,
		SEQ_RUN  = 2'b10
	} adcc_seq_t;

endpackage : adcc_pkg

// *** rtl/adcc_conv_timer.sv ***
/*
 * Conversion sequencer: counts out one conversion either on the CPU
 * clock or on RC oscillator ticks and pulses when it completes.
 * Assumes rcTick is a one-cycle pulse synchronous to mclk.
 */
module adcc_conv_timer
	import adcc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic startPulse,
	input  wire logic useRc,
	input  wire logic rcTick,
	output logic      running,
	output logic      donePulse
);

	adcc_seq_t              state_ff;
	adcc_seq_t              nxt_state;
	logic [CNT_W-1:0]       count_ff;
	logic [CNT_W-1:0]       nxt_count;
	logic                   useRc_ff;
	logic                   nxt_useRc;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Clock source is latched at start so a rewrite mid-conversion is harmless
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_useRc = useRc_ff;
		donePulse = 1'b0;
		case (state_ff)
			SEQ_IDLE: begin
				if (startPulse) begin
					nxt_useRc = useRc;                                  // [R12]
					nxt_state = useRc ? SEQ_SYNC : SEQ_RUN;
					nxt_count = useRc ? RC_SYNC_CLKS : CPU_CONV_CLKS;   // [R15]
				end
			end
			SEQ_SYNC: begin
				if (count_ff == CNT_ONE) begin
					nxt_state = SEQ_RUN;
					nxt_count = RC_TICKS;
				end else begin
					nxt_count = count_ff - CNT_ONE;
				end
			end
			SEQ_RUN: begin
				// RC mode only advances on oscillator ticks
				if (!useRc_ff || rcTick) begin                          // [R12]
					if (count_ff == CNT_ONE) begin
						nxt_state = SEQ_IDLE;
						nxt_count = CNT_ZERO;
						donePulse = 1'b1;                                 // [R15]
					end else begin
						nxt_count = count_ff - CNT_ONE;
					end
				end
			end
			default: begin
				nxt_state = SEQ_IDLE;
				nxt_count = CNT_ZERO;
			end
		endcase
	end

	assign running = (state_ff != SEQ_IDLE);

	// State registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= SEQ_IDLE;
			count_ff <= CNT_ZERO;
			useRc_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			useRc_ff <= nxt_useRc;
		end
	end

endmodule : adcc_conv_timer

// *** verif/adcc_control_sva.sv ***
/*
 * Checker for the converter control block: register port timing,
 * control bit follow-through and conversion start handling.
 * Assumes it is bound to the control block and sees only its ports.
 */
module adcc_control_sva
	import adcc_pkg::*;
(
	input wire logic                        mclk,
	input wire logic                        nrst,
	input wire logic [adcc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [adcc_pkg::DATA_W-1:0] regWdata,
	input wire logic                        regWr,
	input wire logic                        regRd,
	input wire logic [adcc_pkg::DATA_W-1:0] regRdata,
	input wire logic                        converterEnable,
	input wire logic                        analogOut0Enable,
	input wire logic                        analogOut1Enable,
	input wire logic                        rcClockSelect,
	input wire logic [1:0]                  channelSelect,
	input wire logic                        convStart
);
	// ------------------------------------------------
	// Helper logic
	// ------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	logic [7:0] sinceStart_ff;
	// Cycles since launch, saturating so it never wraps
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			sinceStart_ff <= 8'h00;
		else if (convStart)
			sinceStart_ff <= 8'h01;
		else if (sinceStart_ff != 8'h00 && sinceStart_ff != 8'hff)
			sinceStart_ff <= sinceStart_ff + 8'h01;
	end

	sequence s_ctrl_wr;
		regWr && regAddr == ADDR_CTRL;
	endsequence

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	property p_rd_quiet;
		!regRd |=> regRdata == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero");

	property p_out1_follow;
		s_ctrl_wr |=> analogOut1Enable == $past(regWdata[BIT_OUT1_EN]);
	endproperty
	a_out1_follow: assert property (p_out1_follow) else $error("out1 enable wrong");

	property p_en_follow;
		s_ctrl_wr |=> converterEnable == $past(regWdata[BIT_CONV_EN]);
	endproperty
	a_en_follow: assert property (p_en_follow) else $error("converter enable wrong");

	property p_rc_follow;
		s_ctrl_wr |=> rcClockSelect == $past(regWdata[BIT_RC_SEL]);
	endproperty
	a_rc_follow: assert property (p_rc_follow) else $error("rc select wrong");

	property p_start_cause;
		convStart |-> $past(regWr && regAddr == ADDR_CTRL && regWdata[BIT_START]);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("launch without write");

	property p_start_pulse;
		convStart |=> !convStart;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("launch too long");

	property p_no_restart;
		convStart |-> (sinceStart_ff == 8'h00 || sinceStart_ff > 8'd186);
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("launch while busy");

	// Channel and out0 are frozen early in a conversion
	property p_frozen;
		convStart |=> ($stable(analogOut0Enable) && $stable(channelSelect))[*8];
	endproperty
	a_frozen: assert property (p_frozen) else $error("field moved while busy");
endmodule : adcc_control_sva

bind adcc_control adcc_control_sva chk_u (
	.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.converterEnable(converterEnable), .analogOut0Enable(analogOut0Enable),
	.analogOut1Enable(analogOut1Enable), .rcClockSelect(rcClockSelect),
	.channelSelect(channelSelect), .convStart(convStart)
);

// *** verif/testbench.sv ***
/*
 * Self-checking bench for the converter control block, driven through
 * its register port. Assumes the register map and timing of the package.
 */
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
	$display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench
	import adcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  mclk, nrst, regWr, regRd, rcTick;
	logic [ADDR_W-1:0]     regAddr;
	logic [DATA_W-1:0]     regWdata, regRdata, convData;
	logic                  converterEnable, analogOut0Enable, analogOut1Enable;
	logic                  rcClockSelect, convStart, irq;
	logic [1:0]            channelSelect, tickDiv_ff;
	int                    failures, checks;

	adcc_control dut_u (
		.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rcTick(rcTick),
		.convData(convData), .converterEnable(converterEnable),
		.analogOut0Enable(analogOut0Enable), .analogOut1Enable(analogOut1Enable),
		.rcClockSelect(rcClockSelect), .channelSelect(channelSelect),
		.convStart(convStart), .irq(irq)
	);

	// ------------------------------------------------
	// Clock and RC tick, one tick every fourth cycle
	// ------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tickDiv_ff <= 2'h0;
			rcTick     <= 1'b0;
		end else begin
			tickDiv_ff <= tickDiv_ff + 2'h1;
			rcTick     <= (tickDiv_ff == 2'h3);
		end
	end

	// ------------------------------------------------
	// Register port tasks
	// ------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		#1;
	endtask : wr

	// Data stands only in the cycle after the strobe
	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		`CHK(regRdata, e)
	endtask : rdChk

	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// Bounded poll for the done flag
	task automatic waitDone(input int lim);
		for (int n = 0; n < lim; n++) begin
			@(posedge mclk);
			regAddr <= ADDR_CTRL;
			regRd   <= 1'b1;
			@(posedge mclk);
			regRd <= 1'b0;
			#1;
			if (regRdata[BIT_DONE] === 1'b1)
				return;
		end
		failures++;
		results();
	endtask : waitDone

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		{nrst, regWr, regRd} = '0;
		regAddr  = '0;
		regWdata = '0;
		convData = 8'h5a;
		failures = 0;
		checks   = 0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		rdChk(ADDR_CTRL, CTRL_RESET);
		rdChk(ADDR_RESULT, RESULT_RESET);
		wr(ADDR_CTRL, 8'h67);
		`CHK({converterEnable, analogOut1Enable, analogOut0Enable, rcClockSelect}, 4'h7)
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, 8'(i));
			`CHK(channelSelect, 2'(i))
		end
		wr(ADDR_IRQMSK, 8'h03);
		wr(ADDR_CTRL, 8'h81);
		`CHK({converterEnable, analogOut1Enable, analogOut0Enable, rcClockSelect}, 4'h8)
		repeat (2000) @(posedge mclk); // Settling time after enable
		// CPU clocked conversion, exact completion edge
		wr(ADDR_CTRL, 8'h89);
		repeat (183) @(posedge mclk);
		rdChk(ADDR_CTRL, 8'h89);
		// Second start sampled on the very edge that completes the first
		wr(ADDR_CTRL, 8'h89);
		rdChk(ADDR_CTRL, 8'h99);
		rdChk(ADDR_RESULT, 8'h5a);
		`CHK(irq, 1'b1)
		rdChk(ADDR_IRQSTS, 8'h03);
		@(posedge mclk) convData <= 8'ha5;
		wr(ADDR_CTRL, 8'h99);
		rdChk(ADDR_CTRL, 8'h99);
		rdChk(ADDR_IRQSTS, 8'h03);
		wr(ADDR_IRQMSK, 8'h00);
		`CHK(irq, 1'b0)
		wr(ADDR_IRQMSK, 8'h03);
		wr(ADDR_IRQSTS, 8'h03);
		`CHK(irq, 1'b0)
		wr(ADDR_CTRL, 8'hb1);
		rdChk(ADDR_CTRL, 8'h99);
		rdChk(ADDR_RESULT, 8'h5a);
		wr(ADDR_CTRL, 8'h81);
		rdChk(ADDR_CTRL, 8'h81);
		wr(ADDR_CTRL, 8'h22);
		rdChk(ADDR_CTRL, 8'h22);
		// RC clocked conversion with a refused start in the middle
		wr(ADDR_CTRL, 8'h80);
		repeat (2000) @(posedge mclk);
		wr(ADDR_CTRL, 8'h8e);
		wr(ADDR_CTRL, 8'ha8);
		rdChk(ADDR_CTRL, 8'h8a);
		rdChk(ADDR_IRQSTS, 8'h02);
		repeat (200) @(posedge mclk);
		rdChk(ADDR_CTRL, 8'h8a);
		waitDone(400);
		rdChk(ADDR_RESULT, 8'ha5);
		wr(4'hf, 8'hff);
		rdChk(4'hf, 8'h00);
		results();
	end
endmodule : testbench
